/* inc/svm_pkg.sv */
/*
  Supply-voltage monitor controller package: APB register offsets, field positions, reset values, timing counts.
  Assumes a 20 MHz system clock and 32-bit APB data.
*/
package svm_pkg;
  // ----------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] monitor_enable_reg = 8'h00;
  localparam logic [7:0] detector_ctrl_reg = 8'h04;
  localparam logic [7:0] mon1_ctrl_reg = 8'h08;
  localparam logic [7:0] mon2_ctrl_reg = 8'h0c;
  localparam logic [7:0] clock_mode_reg_one = 8'h10;
  localparam logic [7:0] mon1_level_reg = 8'h14;
  localparam logic [7:0] irq_status_reg = 8'h18;
  localparam logic [7:0] irq_mask_reg = 8'h1c;
  localparam logic [7:0] supply_state_reg = 8'h20;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int shared_monitor_enable_bit = 0;
  localparam int detector1_enable_bit = 6;
  localparam int detector2_enable_bit = 7;
  localparam int mon_enable_bit = 0;
  localparam int mon_filter_disable_bit = 1;
  localparam int mon_passage_flag_bit = 2;
  localparam int mon_filter_clk_lo_bit = 4;
  localparam int mon_filter_clk_hi_bit = 5;
  localparam int mon_action_sel_bit = 6;
  localparam int mon_timing_sel_bit = 7;
  localparam int lowspeed_osc_stop_bit = 4;
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0] mon_ctrl_reset = 8'h0a;
  localparam logic lowspeed_osc_stop_reset = 1'b1;
  localparam logic [3:0] mon1_level_reset = 4'h0;
  // ----------------------------------------
  // timing: 125 kHz oscillator derived from the 20 MHz clock
  // ----------------------------------------
  localparam int clk_khz = 20000;
  localparam int lowspeed_osc_khz = 125;
  localparam logic [7:0] osc_div_count = 8'(clk_khz / lowspeed_osc_khz);
  localparam int filter_samples = 3;
endpackage : svm_pkg

/* src/supply_voltage_monitor_ctrl.sv */
/*
  Control logic for two supply-voltage monitors with optional digital filters, APB slave.
  Assumes comparator outputs synchronous to ref_clk_in; high means supply at or above threshold.
*/
// Implementation choices: the address map and register access over APB.
// Operation
// - while monitor 1 disabled, filter clock, filter disable and action accept one write.
// - monitor 1 crossings before the final enable produce no interrupt.
// - monitor 1 crossing during oscillator-on, filter wait or enable write sets its flag.
// - monitor 2 action select: 0 interrupt, 1 reset.
// - while monitor 2 disabled, filter clock, filter disable and action accept one write.
// - monitor 2 crossings before the final enable produce no interrupt.
// - monitor 2 crossing during oscillator-on, filter wait or enable write sets its flag.
`timescale 1ns/1ps
module supply_voltage_monitor_ctrl (
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic above_threshold_one_in,
  input wire logic above_threshold_two_in,
  output logic [3:0] mon1_level_out,
  output logic detector1_enable_out,
  output logic detector2_enable_out,
  output logic irq_out,
  output logic mon1_reset_req_out,
  output logic mon2_reset_req_out
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic shared_en;
    logic det1_en;
    logic det2_en;
    logic [1:0][7:0] mon_ctrl;
    logic osc_stop;
    logic [3:0] level1;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic [7:0] osc_cnt;
    logic [1:0][2:0] filt_div;
    logic [1:0][2:0] filt_hist;
    logic [1:0] filt_level;
    logic [1:0] reset_req;
    logic [31:0] rdata;
  } state_t;

  state_t r;
  state_t next_r;
  logic [1:0] cmp;
  logic osc_tick;

  // filter sampling divisor: 1, 2, 4 or 8 ticks of the low-speed oscillator
  function automatic logic [2:0] div_top(input logic [1:0] sel);
    div_top = 3'((4'h1 << sel) - 4'h1);
  endfunction : div_top

  function automatic logic [7:0] osc_div_count_m1();
    osc_div_count_m1 = svm_pkg::osc_div_count - 8'h01;
  endfunction : osc_div_count_m1

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] reg_off);
    hit = (addr == reg_off);
  endfunction : hit

  assign cmp = {above_threshold_two_in, above_threshold_one_in};
  assign osc_tick = (r.osc_cnt == 8'h00) && !r.osc_stop;
  assign pready_out = 1'b1;
  assign pslverr_out = 1'b0;
  assign prdata_out = r.rdata;
  assign mon1_level_out = r.level1;
  assign detector1_enable_out = r.det1_en;
  assign detector2_enable_out = r.det2_en;
  assign irq_out = |(r.irq_status & r.irq_mask);
  assign mon1_reset_req_out = r.reset_req[0];
  assign mon2_reset_req_out = r.reset_req[1];

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    logic wr;
    logic rd;
    logic [1:0] det_on;
    logic [1:0] crossed;
    logic [1:0] newlvl;
    logic [1:0] fdis;
    logic [1:0] fall_only;
    logic [1:0] hits;
    logic [2:0] hist;
    logic [1:0] dclk;
    wr = psel_in && penable_in && pwrite_in;
    rd = psel_in && !penable_in && !pwrite_in;
    next_r = r;
    newlvl = r.filt_level;
    crossed = 2'b00;
    det_on = {r.det2_en, r.det1_en} & {2{r.shared_en}};
    hits = 2'b00;
    hist = 3'h0;
    dclk = 2'h0;
    fdis = 2'b00;
    fall_only = 2'b00;
    next_r.osc_cnt = (r.osc_stop || r.osc_cnt == 8'h00) ? osc_div_count_m1() : r.osc_cnt - 8'h01;
    for (int m = 0; m < 2; m++) begin
      fdis[m] = r.mon_ctrl[m][svm_pkg::mon_filter_disable_bit];
      dclk = {r.mon_ctrl[m][svm_pkg::mon_filter_clk_hi_bit], r.mon_ctrl[m][svm_pkg::mon_filter_clk_lo_bit]};
      if (!det_on[m]) begin
        newlvl[m] = cmp[m];
        next_r.filt_hist[m] = {3{cmp[m]}};
      end else if (fdis[m]) begin
        newlvl[m] = cmp[m];
      end else if (osc_tick) begin
        if (r.filt_div[m] == 3'h0) begin
          next_r.filt_div[m] = div_top(dclk);
          hist = {r.filt_hist[m][1:0], cmp[m]};
          next_r.filt_hist[m] = hist;
          if (hist == 3'b111) newlvl[m] = 1'b1;
          if (hist == 3'b000) newlvl[m] = 1'b0;
        end else begin
          next_r.filt_div[m] = r.filt_div[m] - 3'h1;
        end
      end
      next_r.filt_level[m] = newlvl[m];
      // timing select 1 watches falls only, 0 watches both directions
      fall_only[m] = r.mon_ctrl[m][svm_pkg::mon_timing_sel_bit];
      crossed[m] = det_on[m] && (newlvl[m] != r.filt_level[m]) && (!fall_only[m] || !newlvl[m]);
      // flag records even before enable, once detector runs
      if (crossed[m]) hits[m] = 1'b1;
    end
    // ---- register writes ----
    if (wr) begin
      if (hit(paddr_in, svm_pkg::monitor_enable_reg))
        next_r.shared_en = pwdata_in[svm_pkg::shared_monitor_enable_bit];
      if (hit(paddr_in, svm_pkg::detector_ctrl_reg)) begin
        next_r.det1_en = pwdata_in[svm_pkg::detector1_enable_bit];
        next_r.det2_en = pwdata_in[svm_pkg::detector2_enable_bit];
      end
      if (hit(paddr_in, svm_pkg::clock_mode_reg_one))
        next_r.osc_stop = pwdata_in[svm_pkg::lowspeed_osc_stop_bit];
      if (hit(paddr_in, svm_pkg::mon1_level_reg))
        next_r.level1 = pwdata_in[3:0];
      if (hit(paddr_in, svm_pkg::irq_mask_reg))
        next_r.irq_mask = pwdata_in[1:0];
      if (hit(paddr_in, svm_pkg::irq_status_reg))
        next_r.irq_status = r.irq_status & ~pwdata_in[1:0];
      for (int m = 0; m < 2; m++) begin
        if (hit(paddr_in, m == 0 ? svm_pkg::mon1_ctrl_reg : svm_pkg::mon2_ctrl_reg)) begin
          // all fields except bit 3 (cleared to 0 by any write) and the flag taken in one write while disabled
          next_r.mon_ctrl[m] = pwdata_in[7:0];
          next_r.mon_ctrl[m][3] = 1'b0;
          // flag only cleared by writing 0, writing 1 keeps it
          next_r.mon_ctrl[m][svm_pkg::mon_passage_flag_bit] =
            r.mon_ctrl[m][svm_pkg::mon_passage_flag_bit] && pwdata_in[svm_pkg::mon_passage_flag_bit];
        end
      end
    end
    // ---- events: set wins over clear ----
    for (int m = 0; m < 2; m++) begin
      if (hits[m]) begin
        next_r.mon_ctrl[m][svm_pkg::mon_passage_flag_bit] = 1'b1;
        if (r.mon_ctrl[m][svm_pkg::mon_enable_bit]) begin
          if (r.mon_ctrl[m][svm_pkg::mon_action_sel_bit])
            next_r.reset_req[m] = 1'b1;
          else
            next_r.irq_status[m] = 1'b1;
        end
      end
    end
    // ---- read data ----
    if (rd) begin
      case (paddr_in)
        svm_pkg::monitor_enable_reg: next_r.rdata = {31'h0000_0000, r.shared_en};
        svm_pkg::detector_ctrl_reg: next_r.rdata = {24'h00_0000, r.det2_en, r.det1_en, 6'h00};
        svm_pkg::mon1_ctrl_reg: next_r.rdata = {24'h00_0000, r.mon_ctrl[0]};
        svm_pkg::mon2_ctrl_reg: next_r.rdata = {24'h00_0000, r.mon_ctrl[1]};
        svm_pkg::clock_mode_reg_one: next_r.rdata = {27'h000_0000, r.osc_stop, 4'h0};
        svm_pkg::mon1_level_reg: next_r.rdata = {28'h000_0000, r.level1};
        svm_pkg::irq_status_reg: next_r.rdata = {30'h0000_0000, r.irq_status};
        svm_pkg::irq_mask_reg: next_r.rdata = {30'h0000_0000, r.irq_mask};
        svm_pkg::supply_state_reg: next_r.rdata = {30'h0000_0000, r.filt_level};
        default: next_r.rdata = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      r <= '0;
      r.mon_ctrl[0] <= svm_pkg::mon_ctrl_reset;
      r.mon_ctrl[1] <= svm_pkg::mon_ctrl_reset;
      r.osc_stop <= svm_pkg::lowspeed_osc_stop_reset;
      r.level1 <= svm_pkg::mon1_level_reset;
    end else begin
      r <= next_r;
    end
  end
endmodule : supply_voltage_monitor_ctrl

/* tb/svm_sva.sv */
/* checker for the monitor controller ports.
   assumes bind to the top module; mirrors control writes from the apb side. */
`timescale 1ns/1ps
module svm_sva (
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic above_threshold_one_in,
  input wire logic above_threshold_two_in,
  input wire logic [3:0] mon1_level_out,
  input wire logic detector1_enable_out,
  input wire logic detector2_enable_out,
  input wire logic irq_out,
  input wire logic mon1_reset_req_out,
  input wire logic mon2_reset_req_out
);
  logic [7:0] m1c;
  logic [7:0] m2c;
  logic [1:0] msk;
  logic shr;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rst_b_in);
  // ----------------------------------------
  // mirror of control writes
  // ----------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      m1c <= 8'h0a;
      m2c <= 8'h0a;
      msk <= 2'h0;
      shr <= 1'b0;
    end else if (psel_in && penable_in && pwrite_in) begin
      if (paddr_in == 8'h00) shr <= pwdata_in[0];
      if (paddr_in == 8'h08) m1c <= pwdata_in[7:0];
      if (paddr_in == 8'h0c) m2c <= pwdata_in[7:0];
      if (paddr_in == 8'h1c) msk <= pwdata_in[1:0];
    end
  end
  sequence wr_to(logic [7:0] a);
    psel_in && penable_in && pwrite_in && paddr_in == a;
  endsequence
  sequence crossed2;
    $changed(above_threshold_two_in) && detector2_enable_out && shr && msk == 2'h3;
  endsequence
  // ----------------------------------------
  // properties
  // ----------------------------------------
  level_write_a: assert property (wr_to(8'h14) |=> mon1_level_out == $past(pwdata_in[3:0]))
    else $error("level select not taken");
  det_write_a: assert property (wr_to(8'h04) |=> {detector2_enable_out, detector1_enable_out} == $past(pwdata_in[7:6]))
    else $error("detector enables not taken");
  irq_cause_a: assert property ($rose(irq_out) |-> (m1c[0] && !m1c[6]) || (m2c[0] && !m2c[6]) || $past(paddr_in) == 8'h1c)
    else $error("interrupt without enabled monitor");
  irq_mask_a: assert property (irq_out |-> msk != 2'h0)
    else $error("interrupt while masked");
  rst1_cause_a: assert property ($rose(mon1_reset_req_out) |-> m1c[0] && m1c[6])
    else $error("monitor 1 reset without enable");
  rst2_cause_a: assert property ($rose(mon2_reset_req_out) |-> m2c[0] && m2c[6])
    else $error("monitor 2 reset without enable");
  rst_sticky_a: assert property (mon1_reset_req_out |=> mon1_reset_req_out)
    else $error("reset request dropped");
  cross_irq_a: assert property (crossed2 and m2c[1:0] == 2'h3 && m2c[7:6] == 2'h0 |-> ##[1:4] irq_out)
    else $error("crossing gave no interrupt");
endmodule : svm_sva
bind supply_voltage_monitor_ctrl svm_sva chk (.ref_clk_in, .rst_b_in, .psel_in, .penable_in, .pwrite_in,
  .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .above_threshold_one_in,
  .above_threshold_two_in, .mon1_level_out, .detector1_enable_out, .detector2_enable_out, .irq_out,
  .mon1_reset_req_out, .mon2_reset_req_out);

/* tb/tb.sv */
/* directed bench for the monitor controller over apb.
   assumes a zero-wait slave; unfiltered comparator paths except the last scenario, which runs monitor 2 through its filter. */
`timescale 1ns/1ps
module tb;
  logic ref_clk_in = 0, rst_b_in = 0, psel_in = 0, penable_in = 0, pwrite_in = 0;
  logic [7:0] paddr_in = 0;
  logic [31:0] pwdata_in = 0, prdata_out, rd;
  logic pready_out, pslverr_out, above_threshold_one_in = 1, above_threshold_two_in = 1;
  logic [3:0] mon1_level_out;
  logic detector1_enable_out, detector2_enable_out, irq_out, mon1_reset_req_out, mon2_reset_req_out;
  int num_errors = 0, samples_checked = 0;
  supply_voltage_monitor_ctrl dut (.ref_clk_in, .rst_b_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
    .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .above_threshold_one_in, .above_threshold_two_in,
    .mon1_level_out, .detector1_enable_out, .detector2_enable_out, .irq_out, .mon1_reset_req_out,
    .mon2_reset_req_out);
  initial begin
    forever #25 ref_clk_in = ~ref_clk_in;
  end
  task automatic tally_and_finish();
    $display("errors %0d of %0d checks", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // ----------------------------------------
  // apb transfer: setup, access until pready
  // ----------------------------------------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge ref_clk_in);
    penable_in <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge ref_clk_in);
      if (pready_out === 1'b1) break;
    end
    if (n == 20) begin
      num_errors++;
      tally_and_finish();
    end
    rd = prdata_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    @(posedge ref_clk_in);
  endtask : apb
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask : rdc
  task automatic wait_hi(ref logic s, input int lim);
    int n;
    for (n = 0; n < lim && s !== 1'b1; n++) @(posedge ref_clk_in);
    if (n == lim) begin
      num_errors++;
      tally_and_finish();
    end
  endtask : wait_hi
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge ref_clk_in);
    rst_b_in <= 1'b1;
    rdc(8'h08, 32'h0000_000a);
    rdc(8'h0c, 32'h0000_000a);
    rdc(8'h40, 32'h0000_0000);
    chk(pslverr_out, 32'h0000_0000);
    apb(1'b1, 8'h00, 32'h0000_0001);
    apb(1'b1, 8'h1c, 32'h0000_0003);
    apb(1'b1, 8'h04, 32'h0000_0080);
    chk({detector1_enable_out, detector2_enable_out}, 32'h0000_0001);
    apb(1'b1, 8'h0c, 32'h0000_0002);
    rdc(8'h0c, 32'h0000_0002);
    above_threshold_two_in <= 1'b0;
    repeat (6) @(posedge ref_clk_in);
    chk(irq_out, 32'h0000_0000);
    rdc(8'h0c, 32'h0000_0006);
    apb(1'b1, 8'h0c, 32'h0000_0003);
    rdc(8'h0c, 32'h0000_0003);
    above_threshold_two_in <= 1'b1;
    wait_hi(irq_out, 20);
    chk(irq_out, 32'h0000_0001);
    repeat (10) @(posedge ref_clk_in);
    rdc(8'h0c, 32'h0000_0007);
    apb(1'b1, 8'h18, 32'h0000_0003);
    rdc(8'h18, 32'h0000_0000);
    chk(irq_out, 32'h0000_0000);
    apb(1'b1, 8'h14, 32'h0000_0005);
    chk(mon1_level_out, 32'h0000_0005);
    apb(1'b1, 8'h04, 32'h0000_00c0);
    apb(1'b1, 8'h08, 32'h0000_00c3);
    rdc(8'h08, 32'h0000_00c3);
    above_threshold_one_in <= 1'b0;
    wait_hi(mon1_reset_req_out, 20);
    chk(mon1_reset_req_out, 32'h0000_0001);
    chk({irq_out, mon2_reset_req_out}, 32'h0000_0000);
    rdc(8'h08, 32'h0000_00c7);
    apb(1'b1, 8'h08, 32'h0000_00c3);
    rdc(8'h08, 32'h0000_00c3);
    apb(1'b1, 8'h0c, 32'h0000_00c0);
    apb(1'b1, 8'h10, 32'h0000_0000);
    repeat (500) @(posedge ref_clk_in);
    apb(1'b1, 8'h0c, 32'h0000_00c1);
    rdc(8'h0c, 32'h0000_00c1);
    above_threshold_two_in <= 1'b0;
    wait_hi(mon2_reset_req_out, 800);
    chk(mon2_reset_req_out, 32'h0000_0001);
    tally_and_finish();
  end
endmodule : tb
